/* File: design/dmm_decoder.sv */
// data memory decoder with the indirect ram access port and pointer file
// assumes a core on the same clock that holds requests until o_ready is high,
// an asynchronous-read program flash and an i/o bus answering in one cycle
`timescale 1ns/1ps
`include "dmm_regs.svh"

// Function
// - program store is 2048 x 16, fetched by an 11-bit counter from zero
// - bytes of the low 1024 program words are readable in data space from 0x4000 to 0x47FF
// - core writes into program area are dropped
// - 0x0000-0x003F decode as i/o, 0x0040-0x013F as sram
// - lock, config, calibration, id and flash ranges decode as printed
// - lock, config, calibration, id and flash are read-only to the core
// - i/o instructions reach all 64 i/o locations from address zero
// - direct accesses only reach 0x0040 through 0x00BF
// - 0x00C0-0x013F reached only indirectly or through the ram port
// - x, y, z reach all data space, with pre-decrement or post-increment
// - pointers x, y, z are built from general registers 26 to 31
// - every sram data access takes two clock cycles
// - virtual 0x0040-0x00FF map straight, 0x0100-0x013F to 0x0000-0x003F
// - ram port address is physical, core accesses use virtual addresses
// - writing port data stores the byte at the held port address
// - reading port data returns the sram byte at the held port address
// - both ram port registers sit in i/o space
// - port address is eight bits, linear over 0 to 255
module dmm_decoder (
  input wire logic i_clk,
  input wire logic i_srst,
  input dmm_pkg::dmm_req_t i_req,
  output logic o_ready,
  output dmm_pkg::dmm_rsp_t o_rsp,
  input wire logic [10:0] i_program_counter,
  output logic [10:0] o_flash_addr,
  input wire logic [15:0] i_flash_word,
  input dmm_pkg::dmm_nvm_t i_nvm,
  output dmm_pkg::dmm_io_t o_io,
  input wire logic [7:0] i_io_rdata,
  input dmm_pkg::dmm_ptr_wr_t i_ptr_wr,
  output logic [2:0][15:0] o_ptr
);
  import dmm_pkg::*;

  // ========================================================================
  // helpers
  function automatic dmm_region_t dmm_region(input logic [15:0] a);
    dmm_region_t r;
    r = DMM_RGN_RSVD;
    if (a <= `DMM_IO_LAST) r = DMM_RGN_IO;
    else if (a >= `DMM_SRAM_FIRST && a <= `DMM_SRAM_LAST) r = DMM_RGN_SRAM;
    else if (a >= `DMM_LOCK_FIRST && a <= `DMM_LOCK_LAST) r = DMM_RGN_LOCK;
    else if (a >= `DMM_CFG_FIRST && a <= `DMM_CFG_LAST) r = DMM_RGN_CFG;
    else if (a >= `DMM_CAL_FIRST && a <= `DMM_CAL_LAST) r = DMM_RGN_CAL;
    else if (a >= `DMM_ID_FIRST && a <= `DMM_ID_LAST) r = DMM_RGN_ID;
    else if (a >= `DMM_FLASH_FIRST && a <= `DMM_FLASH_LAST) r = DMM_RGN_FLASH;
    return r;
  endfunction

  // virtual sram address to physical: the low byte already wraps 0x01xx onto 0x00xx
  function automatic logic [7:0] dmm_phys(input logic [15:0] a);
    return a[7:0];
  endfunction

  function automatic logic dmm_direct_ok(input logic [15:0] a);
    return (a >= `DMM_SRAM_FIRST) && (a <= `DMM_DIRECT_LAST);
  endfunction

  // ========================================================================
  // storage
  dmm_state_t cur;
  dmm_state_t next_cur;
  logic [7:0] mem [0:255];
  logic mem_we;
  logic [7:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic taken;
  logic [15:0] eff;
  logic [15:0] sel_ptr;
  dmm_region_t rgn;
  logic [4:0] ptr_idx;

  assign mem_rdata = mem[mem_raddr];
  assign o_ready = (cur.phase == DMM_IDLE);
  assign o_rsp = cur.rsp;
  assign o_io = cur.io;
  assign o_flash_addr = cur.flash_addr;
  assign o_ptr = cur.ptr;

  // ========================================================================
  // next-state logic
  always_comb begin
    next_cur = cur;
    next_cur.rsp.valid = 1'b0;
    next_cur.io.valid = 1'b0;
    mem_we = 1'b0;
    mem_waddr = `DMM_ZERO_BYTE;
    mem_wdata = `DMM_ZERO_BYTE;
    mem_raddr = dmm_phys(cur.acc_addr);
    taken = 1'b0;
    eff = `DMM_IO_FIRST;
    rgn = DMM_RGN_RSVD;
    sel_ptr = '0;
    ptr_idx = 5'(i_ptr_wr.reg_num - `DMM_PTR_FIRST_REG);
    // core loads of r26..r31 keep the pointer pairs current
    if (i_ptr_wr.valid && i_ptr_wr.reg_num >= `DMM_PTR_FIRST_REG &&
        i_ptr_wr.reg_num <= `DMM_PTR_LAST_REG) begin
      if (ptr_idx[0]) begin
        next_cur.ptr[ptr_idx[2:1]][15:8] = i_ptr_wr.data;
      end else begin
        next_cur.ptr[ptr_idx[2:1]][7:0] = i_ptr_wr.data;
      end
    end
    case (cur.phase)
      DMM_IDLE: begin
        // fetch path owns the flash address between data accesses
        next_cur.flash_addr = i_program_counter;
        if (i_req.valid) begin
          taken = 1'b1;
          sel_ptr = cur.ptr[i_req.sel];
          case (i_req.mode)
            DMM_MODE_IO: eff = {10'h000, i_req.addr[5:0]};
            DMM_MODE_DIRECT: eff = i_req.addr;
            DMM_MODE_IND: eff = sel_ptr;
            DMM_MODE_IND_PREDEC: begin
              eff = 16'(sel_ptr - `DMM_PTR_STEP);
              next_cur.ptr[i_req.sel] = eff;
            end
            DMM_MODE_IND_POSTINC: begin
              eff = sel_ptr;
              next_cur.ptr[i_req.sel] = 16'(sel_ptr + `DMM_PTR_STEP);
            end
            default: eff = i_req.addr;
          endcase
          rgn = dmm_region(eff);
          next_cur.acc_err = 1'b0;
          // direct mode stops at the first 128 sram bytes
          if (i_req.mode == DMM_MODE_DIRECT && !dmm_direct_ok(eff)) begin
            rgn = DMM_RGN_RSVD;
            next_cur.acc_err = 1'b1;
          end else if (rgn == DMM_RGN_RSVD) begin
            next_cur.acc_err = 1'b1;
          end
          next_cur.acc_region = rgn;
          next_cur.acc_addr = eff;
          next_cur.acc_write = i_req.write;
          next_cur.acc_wdata = i_req.wdata;
          // ordinary i/o locations go out to the peripherals
          if (rgn == DMM_RGN_IO && eff[5:0] != `DMM_IO_PORT_ADDR &&
              eff[5:0] != `DMM_IO_PORT_DATA) begin
            next_cur.io.valid = 1'b1;
            next_cur.io.write = i_req.write;
            next_cur.io.addr = eff[5:0];
            next_cur.io.wdata = i_req.wdata;
          end
          if (rgn == DMM_RGN_FLASH) begin
            next_cur.flash_addr = {1'b0, eff[10:1]};
          end
          next_cur.phase = DMM_BUSY;
        end
      end
      DMM_BUSY: begin
        // second cycle of every access: memory and answer
        next_cur.rsp.valid = 1'b1;
        next_cur.rsp.err = cur.acc_err;
        next_cur.rsp.rdata = `DMM_ZERO_BYTE;
        next_cur.phase = DMM_IDLE;
        case (cur.acc_region)
          DMM_RGN_SRAM: begin
            if (cur.acc_write) begin
              mem_we = 1'b1;
              mem_waddr = dmm_phys(cur.acc_addr);
              mem_wdata = cur.acc_wdata;
            end else begin
              next_cur.rsp.rdata = mem_rdata;
            end
          end
          DMM_RGN_IO: begin
            if (cur.acc_addr[5:0] == `DMM_IO_PORT_ADDR) begin
              if (cur.acc_write) begin
                next_cur.port_addr = cur.acc_wdata;
              end else begin
                next_cur.rsp.rdata = cur.port_addr;
              end
            end else if (cur.acc_addr[5:0] == `DMM_IO_PORT_DATA) begin
              // port address is used as is, no virtual translation
              mem_raddr = cur.port_addr;
              if (cur.acc_write) begin
                mem_we = 1'b1;
                mem_waddr = cur.port_addr;
                mem_wdata = cur.acc_wdata;
              end else begin
                next_cur.rsp.rdata = mem_rdata;
              end
            end else if (!cur.acc_write) begin
              next_cur.rsp.rdata = i_io_rdata;
            end
          end
          // read-only mirrors: writes fall through with no effect
          DMM_RGN_LOCK: begin
            if (!cur.acc_write) next_cur.rsp.rdata = i_nvm.lock[cur.acc_addr[0]];
          end
          DMM_RGN_CFG: begin
            if (!cur.acc_write) next_cur.rsp.rdata = i_nvm.cfg[cur.acc_addr[0]];
          end
          DMM_RGN_CAL: begin
            if (!cur.acc_write) next_cur.rsp.rdata = i_nvm.cal[cur.acc_addr[0]];
          end
          DMM_RGN_ID: begin
            if (!cur.acc_write) next_cur.rsp.rdata = i_nvm.id[cur.acc_addr[1:0]];
          end
          DMM_RGN_FLASH: begin
            // low byte of the word first; writes are dropped on purpose
            if (!cur.acc_write) begin
              next_cur.rsp.rdata = cur.acc_addr[0] ? i_flash_word[15:8]
                                                   : i_flash_word[7:0];
            end
          end
          default: next_cur.rsp.rdata = `DMM_ZERO_BYTE;
        endcase
      end
      default: next_cur.phase = DMM_IDLE;
    endcase
  end

  // ========================================================================
  // registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cur <= '0;
      cur.port_addr <= `DMM_PORT_ADDR_RESET;
      cur.flash_addr <= `DMM_PC_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // sram itself has no reset; contents are undefined at power-up
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_busy_then_answer;
    !o_ready ##1 (o_ready && o_rsp.valid);
  endsequence

  sequence s_port_store(logic [7:0] a, logic [7:0] d);
    mem_we && mem_waddr == a && mem_wdata == d;
  endsequence

  chk_two_cycle_access: assert property (
    taken |=> s_busy_then_answer
  ) else $error("access did not answer two cycles after it was taken");

  chk_direct_limit: assert property (
    taken && i_req.mode == DMM_MODE_DIRECT &&
      (i_req.addr < `DMM_SRAM_FIRST || i_req.addr > `DMM_DIRECT_LAST)
      |-> ##2 (o_rsp.err && o_rsp.rdata == `DMM_ZERO_BYTE)
  ) else $error("direct access outside the low sram window was served");

  chk_upper_sram_indirect: assert property (
    taken && i_req.mode == DMM_MODE_DIRECT && i_req.addr > `DMM_DIRECT_LAST &&
      i_req.addr <= `DMM_SRAM_LAST |=> !mem_we && cur.acc_err
  ) else $error("upper sram reached by a direct access");

  chk_read_only_area: assert property (
    mem_we |-> (cur.acc_region == DMM_RGN_SRAM || cur.acc_region == DMM_RGN_IO)
  ) else $error("write reached memory from a read-only region");

  chk_virt_map: assert property (
    mem_we && cur.acc_region == DMM_RGN_SRAM
      |-> mem_waddr == ((cur.acc_addr >= `DMM_VIRT_WRAP) ?
                        8'(cur.acc_addr - `DMM_VIRT_WRAP) : 8'(cur.acc_addr))
  ) else $error("virtual sram address not translated");

  chk_port_write: assert property (
    taken && i_req.write && i_req.mode == DMM_MODE_IO &&
      i_req.addr[5:0] == `DMM_IO_PORT_DATA && !i_ptr_wr.valid
      |=> s_port_store($past(cur.port_addr), $past(i_req.wdata))
  ) else $error("port data write did not store at the port address");

  chk_reserved_zero: assert property (
    taken && !i_req.write && rgn == DMM_RGN_RSVD
      |-> ##2 (o_rsp.valid && o_rsp.err && o_rsp.rdata == `DMM_ZERO_BYTE)
  ) else $error("reserved read returned nonzero");

  chk_ptr_postinc: assert property (
    taken && i_req.mode == DMM_MODE_IND_POSTINC && !i_ptr_wr.valid
      |=> o_ptr[$past(i_req.sel)] == 16'($past(o_ptr[i_req.sel]) + `DMM_PTR_STEP)
  ) else $error("pointer not incremented after access");

  chk_ptr_predec: assert property (
    taken && i_req.mode == DMM_MODE_IND_PREDEC && !i_ptr_wr.valid
      |=> o_ptr[$past(i_req.sel)] == 16'($past(o_ptr[i_req.sel]) - `DMM_PTR_STEP) &&
          cur.acc_addr == o_ptr[$past(i_req.sel)]
  ) else $error("pre-decrement address differs from the new pointer");

  // byte offset from the window base, halved, is the word put on the flash bus
  chk_flash_map: assert property (
    taken && rgn == DMM_RGN_FLASH
      |=> o_flash_addr == 11'(($past(eff) - `DMM_FLASH_FIRST) >> 1)
  ) else $error("flash word address wrong for mapped read");

  // the edge right after reset still shows the reset fetch address, so skip it
  chk_fetch_addr: assert property (
    o_ready && $past(o_ready) && !$past(i_srst)
      |-> o_flash_addr == $past(i_program_counter)
  ) else $error("flash address does not follow the program counter");

  // mirrors and flash: a core write must leave memory and i/o untouched
  chk_read_only_drop: assert property (
    taken && i_req.write && rgn inside {DMM_RGN_LOCK, DMM_RGN_CFG, DMM_RGN_CAL,
      DMM_RGN_ID, DMM_RGN_FLASH} |=> !mem_we && !o_io.valid
  ) else $error("write to a read-only region had an effect");

  // reserved writes are swallowed and flagged
  chk_reserved_write: assert property (
    taken && i_req.write && rgn == DMM_RGN_RSVD |=> !mem_we && !o_io.valid && cur.acc_err
  ) else $error("reserved write had an effect");

  // ordinary i/o locations go out with their own address and direction
  chk_io_forward: assert property (
    taken && i_req.mode == DMM_MODE_IO && i_req.addr[5:0] != `DMM_IO_PORT_ADDR &&
      i_req.addr[5:0] != `DMM_IO_PORT_DATA
      |=> o_io.valid && o_io.addr == $past(i_req.addr[5:0]) && o_io.write == $past(i_req.write)
  ) else $error("i/o access not forwarded to the peripherals");

  // both port registers live in i/o space but are served here, not outside
  chk_port_regs_local: assert property (
    taken && i_req.mode == DMM_MODE_IO &&
      (i_req.addr[5:0] == `DMM_IO_PORT_ADDR || i_req.addr[5:0] == `DMM_IO_PORT_DATA)
      |=> !o_io.valid
  ) else $error("port register access leaked onto the i/o bus");

  // a port data read fetches at the held physical address and answers with it
  chk_port_read: assert property (
    taken && !i_req.write && i_req.mode == DMM_MODE_IO &&
      i_req.addr[5:0] == `DMM_IO_PORT_DATA
      |=> mem_raddr == $past(cur.port_addr) ##1 o_rsp.rdata == $past(mem_rdata)
  ) else $error("port data read did not return the addressed byte");

  // the lowest pointer register loads the low byte of x
  chk_ptr_load: assert property (
    i_ptr_wr.valid && i_ptr_wr.reg_num == `DMM_PTR_FIRST_REG && !taken
      |=> o_ptr[DMM_PTR_X][7:0] == $past(i_ptr_wr.data)
  ) else $error("pointer register load did not reach the pointer");

endmodule

/* File: design/dmm_regs.svh */
// constants of the data memory decoder: address ranges, port locations, steps
// assumes a 16-bit byte data address space and a 6-bit i/o space
`ifndef DMM_REGS_SVH
`define DMM_REGS_SVH

// ==========================================================================
// data address ranges
`define DMM_IO_FIRST 16'h0000
`define DMM_IO_LAST 16'h003F
`define DMM_SRAM_FIRST 16'h0040
`define DMM_DIRECT_LAST 16'h00BF
`define DMM_SRAM_LAST 16'h013F
`define DMM_VIRT_WRAP 16'h0100
`define DMM_LOCK_FIRST 16'h3F00
`define DMM_LOCK_LAST 16'h3F01
`define DMM_CFG_FIRST 16'h3F40
`define DMM_CFG_LAST 16'h3F41
`define DMM_CAL_FIRST 16'h3F80
`define DMM_CAL_LAST 16'h3F81
`define DMM_ID_FIRST 16'h3FC0
`define DMM_ID_LAST 16'h3FC3
`define DMM_FLASH_FIRST 16'h4000
`define DMM_FLASH_LAST 16'h47FF

// ==========================================================================
// i/o locations of the ram access port
`define DMM_IO_PORT_ADDR 6'h20
`define DMM_IO_PORT_DATA 6'h1F

// ==========================================================================
// pointer registers, steps and reset values
`define DMM_PTR_FIRST_REG 5'h1A
`define DMM_PTR_LAST_REG 5'h1F
`define DMM_PTR_STEP 16'h0001
`define DMM_PORT_ADDR_RESET 8'h00
`define DMM_PC_RESET 11'h000
`define DMM_ZERO_BYTE 8'h00

`endif

/* File: design/dmm_pkg.sv */
// types of the data memory decoder: requests, answers, i/o and state
// assumes dmm_regs.svh for all numeric constants
package dmm_pkg;

  // ========================================================================
  // access kinds issued by the core
  typedef enum logic [2:0] {
    DMM_MODE_IO,
    DMM_MODE_DIRECT,
    DMM_MODE_IND,
    DMM_MODE_IND_PREDEC,
    DMM_MODE_IND_POSTINC
  } dmm_mode_t;

  typedef enum logic [1:0] {
    DMM_PTR_X,
    DMM_PTR_Y,
    DMM_PTR_Z
  } dmm_ptr_sel_t;

  typedef enum logic [2:0] {
    DMM_RGN_IO,
    DMM_RGN_SRAM,
    DMM_RGN_LOCK,
    DMM_RGN_CFG,
    DMM_RGN_CAL,
    DMM_RGN_ID,
    DMM_RGN_FLASH,
    DMM_RGN_RSVD
  } dmm_region_t;

  typedef enum logic {
    DMM_IDLE,
    DMM_BUSY
  } dmm_phase_t;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    dmm_mode_t mode;
    dmm_ptr_sel_t sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmm_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] rdata;
  } dmm_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } dmm_io_t;

  typedef struct packed {
    logic valid;
    logic [4:0] reg_num;
    logic [7:0] data;
  } dmm_ptr_wr_t;

  typedef struct packed {
    logic [1:0][7:0] lock;
    logic [1:0][7:0] cfg;
    logic [1:0][7:0] cal;
    logic [3:0][7:0] id;
  } dmm_nvm_t;

  // ========================================================================
  // whole state of the decoder
  typedef struct packed {
    dmm_phase_t phase;
    logic [7:0] port_addr;
    logic [2:0][15:0] ptr;
    dmm_region_t acc_region;
    logic acc_write;
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata;
    logic acc_err;
    dmm_rsp_t rsp;
    dmm_io_t io;
    logic [10:0] flash_addr;
  } dmm_state_t;

endpackage

/* File: tb/dmm_far_model.sv */
// far-side model of the decoder: program flash and a small i/o register bank
// assumes one clock shared with the decoder and single-cycle i/o requests
`timescale 1ns/1ps

module dmm_far_model (
  input wire logic i_clk,
  input wire logic [10:0] i_flash_addr,
  output logic [15:0] o_flash_word,
  input dmm_pkg::dmm_io_t i_io,
  output logic [7:0] o_io_rdata
);
  import dmm_pkg::*;

  logic [7:0] io_mem [0:63];

  // ==========================================================================
  // flash: asynchronous read, word pattern derived from the word address
  assign o_flash_word = 16'hC000 ^ {i_flash_addr[7:0], i_flash_addr[7:0]};

  // ==========================================================================
  // i/o bank: idle bus shows inverted data so a late sample cannot pass
  assign o_io_rdata = i_io.valid ? io_mem[i_io.addr] : ~io_mem[i_io.addr];

  // preset pattern so reads never see unknowns
  initial begin
    for (int i = 0; i < 64; i++) begin
      io_mem[i] = 8'(i) ^ 8'h80;
    end
  end

  // writes land at the edge that ends the i/o pulse
  always @(posedge i_clk) begin
    if (i_io.valid && i_io.write) begin
      io_mem[i_io.addr] <= i_io.wdata;
    end
  end
endmodule

/* File: tb/data_memory_map_ram_port_tb.sv */
// self-checking bench of the data memory decoder and its ram access port
// assumes the far-side model for flash and i/o, nvm bytes held constant
`timescale 1ns/1ps
`include "dmm_regs.svh"

module data_memory_map_ram_port_tb;
  import dmm_pkg::*;

  typedef struct packed {
    logic w;
    dmm_mode_t m;
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] er;
    logic ee;
  } dmm_row_t;

  logic i_clk;
  logic i_srst;
  dmm_req_t req;
  logic o_ready;
  dmm_rsp_t o_rsp;
  logic [10:0] pc;
  logic [10:0] o_flash_addr;
  logic [15:0] flash_word;
  dmm_nvm_t nvm;
  dmm_io_t o_io;
  logic [7:0] io_rdata;
  dmm_ptr_wr_t ptr_wr;
  logic [2:0][15:0] o_ptr;
  logic [7:0] rd;
  logic er;
  int num_errors = 0;
  int samples_checked = 0;
  dmm_row_t rows [] = '{
    '{1'b1, DMM_MODE_DIRECT, 16'h0050, 8'hA1, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_DIRECT, 16'h0050, 8'h00, 8'hA1, 1'b0},
    '{1'b1, DMM_MODE_DIRECT, 16'h00BF, 8'hB2, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_DIRECT, 16'h00BF, 8'h00, 8'hB2, 1'b0},
    '{1'b0, DMM_MODE_DIRECT, 16'h003F, 8'h00, 8'h00, 1'b1},
    '{1'b1, DMM_MODE_IND, 16'h00C0, 8'hC3, 8'h00, 1'b0},
    '{1'b1, DMM_MODE_DIRECT, 16'h00C0, 8'hEE, 8'h00, 1'b1},
    '{1'b0, DMM_MODE_DIRECT, 16'h00C0, 8'h00, 8'h00, 1'b1},
    '{1'b0, DMM_MODE_IND, 16'h00C0, 8'h00, 8'hC3, 1'b0},
    '{1'b1, DMM_MODE_IND, 16'h0100, 8'hD4, 8'h00, 1'b0},
    '{1'b1, DMM_MODE_IND, 16'h013F, 8'hE5, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h013F, 8'h00, 8'hE5, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h0140, 8'h00, 8'h00, 1'b1},
    '{1'b1, DMM_MODE_IND, 16'h3F00, 8'hFF, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h3F00, 8'h00, 8'h10, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h3F41, 8'h00, 8'h21, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h3F80, 8'h00, 8'h30, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h3FC3, 8'h00, 8'h43, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h3FC4, 8'h00, 8'h00, 1'b1},
    '{1'b0, DMM_MODE_IND, 16'h4003, 8'h00, 8'hC1, 1'b0},
    '{1'b1, DMM_MODE_IND, 16'h4000, 8'h55, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h4000, 8'h00, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h47FF, 8'h00, 8'h3F, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h4800, 8'h00, 8'h00, 1'b1},
    '{1'b1, DMM_MODE_IO, 16'h0006, 8'h66, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_IO, 16'h0006, 8'h00, 8'h66, 1'b0},
    '{1'b0, DMM_MODE_IO, 16'h003F, 8'h00, 8'hBF, 1'b0},
    '{1'b1, DMM_MODE_IO, 16'h0020, 8'h00, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_IO, 16'h001F, 8'h00, 8'hD4, 1'b0},
    '{1'b1, DMM_MODE_IO, 16'h0020, 8'h50, 8'h00, 1'b0},
    '{1'b1, DMM_MODE_IO, 16'h001F, 8'h77, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_DIRECT, 16'h0050, 8'h00, 8'h77, 1'b0},
    '{1'b0, DMM_MODE_IO, 16'h0020, 8'h00, 8'h50, 1'b0},
    '{1'b1, DMM_MODE_IO, 16'h0020, 8'hFF, 8'h00, 1'b0},
    '{1'b1, DMM_MODE_IO, 16'h001F, 8'h99, 8'h00, 1'b0},
    '{1'b0, DMM_MODE_IND, 16'h00FF, 8'h00, 8'h99, 1'b0}
  };

  // ==========================================================================
  // design and far side
  dmm_decoder dmm_decoder_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_req(req), .o_ready(o_ready), .o_rsp(o_rsp),
    .i_program_counter(pc), .o_flash_addr(o_flash_addr), .i_flash_word(flash_word),
    .i_nvm(nvm), .o_io(o_io), .i_io_rdata(io_rdata), .i_ptr_wr(ptr_wr), .o_ptr(o_ptr)
  );

  dmm_far_model dmm_far_model_inst (
    .i_clk(i_clk), .i_flash_addr(o_flash_addr), .o_flash_word(flash_word),
    .i_io(o_io), .o_io_rdata(io_rdata)
  );

  // ==========================================================================
  // clock and shared tasks
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // pointer bytes go low first, then high; the register updates a cycle later
  task automatic setp(input int p, input logic [15:0] v);
    @(posedge i_clk);
    ptr_wr <= '{1'b1, 5'(26 + 2 * p), v[7:0]};
    @(posedge i_clk);
    ptr_wr <= '{1'b1, 5'(27 + 2 * p), v[15:8]};
    @(posedge i_clk);
    ptr_wr.valid <= 1'b0;
    #1 chk("pointer", o_ptr[p], v);
  endtask

  // one core access: held until taken, answer two edges after taking
  task automatic acc(input logic w, input dmm_mode_t m, input dmm_ptr_sel_t s,
                     input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req <= '{1'b1, w, m, s, a, d};
    @(posedge i_clk);
    req.valid <= 1'b0;
    #1 chk("ready_busy", 16'(o_ready), 16'h0000);
    @(posedge i_clk);
    #1 chk("rsp_valid", 16'(o_rsp.valid), 16'h0001);
    rd = o_rsp.rdata;
    er = o_rsp.err;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the whole sequence needs well under 1500 cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    finish_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    i_srst = 1'b1;
    req = '0;
    pc = 11'h000;
    ptr_wr = '0;
    nvm = '{lock: {8'h11, 8'h10}, cfg: {8'h21, 8'h20}, cal: {8'h31, 8'h30},
            id: {8'h43, 8'h42, 8'h41, 8'h40}};
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    #1 chk("reset_ready", 16'(o_ready), 16'h0001);
    chk("reset_ptr", o_ptr[2], 16'h0000);
    chk("reset_io", 16'(o_io.valid), 16'h0000);
    // table of ordinary accesses; port address is always written first
    foreach (rows[i]) begin
      if (rows[i].m == DMM_MODE_IND) begin
        setp(2, rows[i].a);
      end
      acc(rows[i].w, rows[i].m, DMM_PTR_Z, rows[i].a, rows[i].d);
      if (!rows[i].w) begin
        chk("rdata", 16'(rd), 16'(rows[i].er));
      end
      chk("err", 16'(er), 16'(rows[i].ee));
    end
    // post-increment through y reads first, then steps the pointer
    setp(1, 16'h00C0);
    acc(1'b0, DMM_MODE_IND_POSTINC, DMM_PTR_Y, 16'h0000, 8'h00);
    chk("postinc_data", 16'(rd), 16'h00C3);
    chk("postinc_ptr", o_ptr[1], 16'h00C1);
    // pre-decrement through x lands on virtual 0x0100, physical zero
    setp(0, 16'h0101);
    acc(1'b0, DMM_MODE_IND_PREDEC, DMM_PTR_X, 16'h0000, 8'h00);
    chk("predec_data", 16'(rd), 16'h00D4);
    chk("predec_ptr", o_ptr[0], 16'h0100);
    // register 25 is outside the pointer file and must be ignored
    @(posedge i_clk);
    ptr_wr <= '{1'b1, 5'h19, 8'h77};
    @(posedge i_clk);
    ptr_wr.valid <= 1'b0;
    #1 chk("ptr_ignored", o_ptr[0], 16'h0100);
    // fetch address follows the program counter at the top word
    @(posedge i_clk);
    pc <= 11'h7FF;
    repeat (2) @(posedge i_clk);
    #1 chk("fetch_addr", 16'(o_flash_addr), 16'h07FF);
    // reset in mid-run clears the pointers again
    @(posedge i_clk);
    i_srst <= 1'b1;
    @(posedge i_clk);
    i_srst <= 1'b0;
    #1 chk("rerst_ptr", o_ptr[0], 16'h0000);
    // sram keeps its contents across reset; first access right after release
    acc(1'b0, DMM_MODE_DIRECT, DMM_PTR_Z, 16'h0050, 8'h00);
    chk("rerst_data", 16'(rd), 16'h0077);
    chk("rerst_err", 16'(er), 16'h0000);
    finish_test();
  end
endmodule
